/* File: pkg/conv_pkg.sv */
// Constants shared by the converter compare and scan control logic
package conv_pkg;

    // Register byte offsets (aliases sit at +0x4, +0x8, +0xC)
    localparam logic [11:0] OFF_BUF14 = 12'h7E0;
    localparam logic [11:0] OFF_BUF15 = 12'h7F0;
    localparam logic [11:0] OFF_CON_MAIN = 12'h800;
    localparam logic [11:0] OFF_CON_REFBUF = 12'h810;
    localparam logic [11:0] OFF_CON_TIMING = 12'h820;
    localparam logic [11:0] OFF_CHAN_SEL = 12'h840;
    localparam logic [11:0] OFF_SCAN_SEL = 12'h850;
    localparam logic [11:0] OFF_CMP_SCAN = 12'h870;
    localparam logic [11:0] OFF_HIT = 12'h880;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h890;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h8A0;

    // Implemented bits of each register
    localparam logic [31:0] MASK_BUF = 32'hFFFF_FFFF;
    localparam logic [31:0] MASK_CON_MAIN = 32'h0000_A7EF;
    localparam logic [31:0] MASK_CON_REFBUF = 32'h0000_FCBE;
    localparam logic [31:0] MASK_CON_TIMING = 32'h0000_DFFF;
    localparam logic [31:0] MASK_CHAN_SEL = 32'h0000_00FF;
    localparam logic [31:0] MASK_SCAN_SEL = 32'h7000_3FFF;
    localparam logic [31:0] MASK_CMP_SCAN = 32'h0000_D30F;
    localparam logic [31:0] MASK_HIT = 32'h0000_3FFF;
    localparam logic [31:0] MASK_IRQ = 32'h0000_0007;

    // Reset value of every register
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

    // Field positions
    localparam int POS_ON = 15;
    localparam int POS_ORDINARY_SCAN = 10;
    localparam int POS_SMPI_LO = 2;
    localparam int POS_AUTO_SCAN = 15;
    localparam int POS_ASINT_LO = 8;
    localparam int POS_WM_LO = 2;
    localparam int POS_CM_LO = 0;

    // Interrupt status bit positions
    localparam int IRQ_COUNT = 0;
    localparam int IRQ_MATCH = 1;
    localparam int IRQ_SCAN = 2;

    // Documented channel count of the hit and scan fields
    localparam int CHANNEL_COUNT = 14;

    // Alias write kinds from address bits 3:2
    typedef enum logic [1:0] {
        WR_PLAIN,
        WR_CLEAR,
        WR_SET,
        WR_INVERT
    } write_kind_t;

    // Compare modes
    typedef enum logic [1:0] {
        CMP_LESS,
        CMP_GREATER,
        CMP_INSIDE,
        CMP_OUTSIDE
    } compare_mode_t;

    // Apply a plain, clear, set or invert write and drop unimplemented bits
    function automatic logic [31:0] apply_write(input logic [31:0] cur, input logic [31:0] wd,
                                                input write_kind_t kind, input logic [31:0] mask);
        logic [31:0] res;
        res = wd;
        unique case (kind)
            WR_PLAIN: res = wd;
            WR_CLEAR: res = cur & ~wd;
            WR_SET: res = cur | wd;
            WR_INVERT: res = cur ^ wd;
        endcase
        return res & mask;
    endfunction : apply_write

endpackage : conv_pkg

/* File: pkg/compare_if.sv */
// Carrier between the register block and the compare unit
`timescale 1ns/100ps
interface compare_if #(parameter int RESULT_W = 12);
    logic enable;
    logic sample_valid;
    logic [RESULT_W-1:0] sample;
    logic [4:0] channel;
    logic [1:0] mode;
    logic [31:0] low_bound;
    logic [31:0] high_bound;
    logic match;
    logic [4:0] match_channel;

    modport ctrl (output enable, sample_valid, sample, channel, mode, low_bound, high_bound,
                  input match, match_channel);
    modport unit (input enable, sample_valid, sample, channel, mode, low_bound, high_bound,
                  output match, match_channel);
endinterface : compare_if

/* File: src/compare_unit.sv */
// Compares each conversion result against the buffer pair
`timescale 1ns/100ps
module compare_unit
    import conv_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Compare carrier
    compare_if.unit cmp
);

    ////////////////////////////////////////////////////////////////////////////////
    wire [31:0] result_wide = 32'(cmp.sample);
    wire below = result_wide < cmp.low_bound;
    wire above = result_wide > cmp.low_bound;
    wire in_window = (result_wide >= cmp.low_bound) && (result_wide <= cmp.high_bound);
    logic hit;

    always_comb
    begin
        hit = 1'b0;
        unique case (compare_mode_t'(cmp.mode))
            CMP_LESS: hit = below; // see [R01]
            CMP_GREATER: hit = above; // see [R01]
            CMP_INSIDE: hit = in_window; // see [R02]
            CMP_OUTSIDE: hit = !in_window; // see [R02]
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cmp.match <= 1'b0;
            cmp.match_channel <= 5'h00;
        end
        else
        begin
            cmp.match <= cmp.enable && cmp.sample_valid && hit;
            cmp.match_channel <= cmp.channel;
        end
    end

endmodule : compare_unit

/* File: src/converter_compare_scan_control.sv */
// Converter control, compare and scan registers behind an APB slave
// Notes on behaviour
// [R01] Mode 00 matches result below buffer value; mode 01 matches result above it.
// [R02] Mode 10 matches inside the buffer-pair window; mode 11 matches outside it.
// [R03] Auto-scan enabled overrides ordinary scan enable and samples-per-interrupt count.
// [R04] Auto-scan interrupt selection acts only while auto-scan is enabled.
// [R05] Interrupt raised after samples-per-interrupt plus one completed conversions.
// [R06] Each register except the interrupt status has clear, set, invert aliases at +0x4, +0x8, +0xC.
// [R07] Unimplemented bits read zero and ignore writes.
// [R08] Reset loads every register of the block with zero.
// [R09] A compare match sets that channel's bit in the hit register.
`timescale 1ns/100ps
module converter_compare_scan_control
    import conv_pkg::*;
#(
    parameter int RESULT_W = 12,
    parameter int CHANNELS = CHANNEL_COUNT
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter results
    input wire logic conv_valid,
    input wire logic [RESULT_W-1:0] conv_result,
    input wire logic [4:0] conv_channel,
    input wire logic scan_end,
    // Control outputs
    output logic converter_on,
    output logic scan_active,
    output logic [CHANNELS-1:0] scan_inputs,
    output logic compare_match,
    // Interrupt
    output logic irq
);

    if (RESULT_W < 1 || RESULT_W > 32)
    begin : check_result_w
        $error("RESULT_W must lie between 1 and 32");
    end
    if (CHANNELS < 1 || CHANNELS > CHANNEL_COUNT)
    begin : check_channels
        $error("CHANNELS must lie between 1 and 14");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0] buf14;
    logic [31:0] buf15;
    logic [31:0] con_main;
    logic [31:0] con_refbuf;
    logic [31:0] con_timing;
    logic [31:0] chan_sel;
    logic [31:0] scan_sel;
    logic [31:0] cmp_scan;
    logic [31:0] hit_flags;
    logic [31:0] irq_status;
    logic [31:0] irq_mask;
    logic [3:0] sample_count;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire [11:0] base_addr = {paddr[11:4], 4'h0};
    wire write_kind_t wkind = write_kind_t'(paddr[3:2]);
    wire setup_phase = psel && !penable;
    wire access_phase = psel && penable;
    wire wr_access = access_phase && pwrite;
    wire rd_access = access_phase && !pwrite;

    wire sel_buf14 = base_addr == OFF_BUF14;
    wire sel_buf15 = base_addr == OFF_BUF15;
    wire sel_con_main = base_addr == OFF_CON_MAIN;
    wire sel_con_refbuf = base_addr == OFF_CON_REFBUF;
    wire sel_con_timing = base_addr == OFF_CON_TIMING;
    wire sel_chan_sel = base_addr == OFF_CHAN_SEL;
    wire sel_scan_sel = base_addr == OFF_SCAN_SEL;
    wire sel_cmp_scan = base_addr == OFF_CMP_SCAN;
    wire sel_hit = base_addr == OFF_HIT;
    wire sel_irq_status = base_addr == OFF_IRQ_STATUS;
    wire sel_irq_mask = base_addr == OFF_IRQ_MASK;
    wire mapped = sel_buf14 || sel_buf15 || sel_con_main || sel_con_refbuf || sel_con_timing
        || sel_chan_sel || sel_scan_sel || sel_cmp_scan || sel_hit || sel_irq_status
        || sel_irq_mask;

    // Read mux; every register already holds zero in unimplemented bits
    logic [31:0] read_value;
    always_comb
    begin
        read_value = 32'h0000_0000;
        if (sel_buf14)
            read_value = buf14;
        else if (sel_buf15)
            read_value = buf15;
        else if (sel_con_main)
            read_value = con_main;
        else if (sel_con_refbuf)
            read_value = con_refbuf;
        else if (sel_con_timing)
            read_value = con_timing;
        else if (sel_chan_sel)
            read_value = chan_sel;
        else if (sel_scan_sel)
            read_value = scan_sel;
        else if (sel_cmp_scan)
            read_value = cmp_scan;
        else if (sel_hit)
            read_value = hit_flags;
        else if (sel_irq_status)
            read_value = irq_status;
        else if (sel_irq_mask)
            read_value = irq_mask;
    end

    // Answer is prepared at the setup edge, so the access phase ends at once
    assign pready = access_phase;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata <= pwrite ? 32'h0000_0000 : read_value;
            pslverr <= !mapped;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes through the plain and alias addresses
    wire wr_ok = wr_access && mapped;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            buf14 <= RESET_VALUE; // see [R08]
            buf15 <= RESET_VALUE;
            con_main <= RESET_VALUE;
            con_refbuf <= RESET_VALUE;
            con_timing <= RESET_VALUE;
            chan_sel <= RESET_VALUE;
            scan_sel <= RESET_VALUE;
            cmp_scan <= RESET_VALUE;
            irq_mask <= RESET_VALUE;
        end
        else if (wr_ok)
        begin
            if (sel_buf14)
                buf14 <= apply_write(buf14, pwdata, wkind, MASK_BUF); // see [R06]
            if (sel_buf15)
                buf15 <= apply_write(buf15, pwdata, wkind, MASK_BUF);
            if (sel_con_main)
                con_main <= apply_write(con_main, pwdata, wkind, MASK_CON_MAIN); // see [R07]
            if (sel_con_refbuf)
                con_refbuf <= apply_write(con_refbuf, pwdata, wkind, MASK_CON_REFBUF);
            if (sel_con_timing)
                con_timing <= apply_write(con_timing, pwdata, wkind, MASK_CON_TIMING);
            if (sel_chan_sel)
                chan_sel <= apply_write(chan_sel, pwdata, wkind, MASK_CHAN_SEL);
            if (sel_scan_sel)
                scan_sel <= apply_write(scan_sel, pwdata, wkind, MASK_SCAN_SEL);
            if (sel_cmp_scan)
                cmp_scan <= apply_write(cmp_scan, pwdata, wkind, MASK_CMP_SCAN);
            if (sel_irq_mask)
                irq_mask <= apply_write(irq_mask, pwdata, wkind, MASK_IRQ);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Field decode
    wire conv_enabled = con_main[POS_ON];
    wire ordinary_scan_enable = con_refbuf[POS_ORDINARY_SCAN];
    wire [3:0] samples_per_interrupt = con_refbuf[POS_SMPI_LO +: 4];
    wire auto_scan_enable = cmp_scan[POS_AUTO_SCAN];
    wire [1:0] auto_scan_interrupt_select = cmp_scan[POS_ASINT_LO +: 2];
    wire [1:0] write_mode_select = cmp_scan[POS_WM_LO +: 2];
    wire [1:0] compare_mode_select = cmp_scan[POS_CM_LO +: 2];
    wire [CHANNELS-1:0] scan_input_bits = scan_sel[CHANNELS-1:0];

    wire sample_taken = conv_valid && conv_enabled;
    wire count_done = sample_count == samples_per_interrupt;

    ////////////////////////////////////////////////////////////////////////////////
    // Compare unit
    compare_if #(.RESULT_W(RESULT_W)) cmp ();

    assign cmp.enable = conv_enabled && (write_mode_select != 2'b00);
    assign cmp.sample_valid = conv_valid;
    assign cmp.sample = conv_result;
    assign cmp.channel = conv_channel;
    assign cmp.mode = compare_mode_select;
    assign cmp.low_bound = buf14;
    assign cmp.high_bound = buf15;

    compare_unit u_compare (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .cmp(cmp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Channel hit flags; a hit wins over a clear in the same cycle
    wire match_in_range = cmp.match && (cmp.match_channel < 5'(CHANNELS));
    wire [31:0] hit_set = match_in_range ? (32'h1 << cmp.match_channel) : 32'h0;
    wire hit_clear_write = wr_ok && sel_hit && (wkind != WR_PLAIN);
    wire [31:0] hit_after_write = hit_clear_write
        ? apply_write(hit_flags, pwdata, wkind, MASK_HIT) : hit_flags;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            hit_flags <= RESET_VALUE;
        else
            hit_flags <= (hit_after_write | hit_set) & MASK_HIT; // see [R09]
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion counter for the samples-per-interrupt event
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            sample_count <= 4'h0;
        else if (auto_scan_enable || !conv_enabled)
            sample_count <= 4'h0; // see [R03]
        else if (sample_taken)
            sample_count <= count_done ? 4'h0 : sample_count + 4'h1; // see [R05]
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt events
    wire ev_count = sample_taken && count_done && !auto_scan_enable; // see [R03] [R05]
    wire ev_match = cmp.match && (!auto_scan_enable || auto_scan_interrupt_select[0]); // see [R04]
    wire ev_scan = scan_end && conv_enabled && auto_scan_enable
        && auto_scan_interrupt_select[1]; // see [R04]
    wire [31:0] irq_events = {29'h0, ev_scan, ev_match, ev_count};
    wire status_read = rd_access && sel_irq_status;
    // A read clears only the bits it returned, so an event after the setup edge is kept
    wire [31:0] status_kept = status_read ? (irq_status & ~prdata) : irq_status;
    wire [31:0] next_irq_status = (status_kept | irq_events) & MASK_IRQ;

    // Reading the status clears it; an event in the same cycle survives
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            irq_status <= RESET_VALUE;
        else
            irq_status <= next_irq_status;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            converter_on <= 1'b0;
            scan_active <= 1'b0;
            scan_inputs <= '0;
            compare_match <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            converter_on <= conv_enabled;
            scan_active <= conv_enabled && (auto_scan_enable || ordinary_scan_enable); // see [R03]
            scan_inputs <= scan_input_bits;
            compare_match <= cmp.match;
            irq <= |(next_irq_status & irq_mask);
        end
    end

endmodule : converter_compare_scan_control

/* File: bench/converter_compare_scan_control_chk.sv */
// Port assertions for the converter compare and scan control block
`timescale 1ns/100ps
module converter_compare_scan_control_chk
    import conv_pkg::*;
#(
    parameter int RESULT_W = 12,
    parameter int CHANNELS = CHANNEL_COUNT
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // APB
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Converter side
    input wire logic conv_valid,
    input wire logic [RESULT_W-1:0] conv_result,
    input wire logic [4:0] conv_channel,
    input wire logic scan_end,
    input wire logic converter_on,
    input wire logic scan_active,
    input wire logic [CHANNELS-1:0] scan_inputs,
    input wire logic compare_match,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    wire logic [7:0] base = paddr[11:4];
    wire logic [31:0] rd_mask = (base == 8'h7E || base == 8'h7F) ? MASK_BUF :
        (base == 8'h80) ? MASK_CON_MAIN : (base == 8'h81) ? MASK_CON_REFBUF :
        (base == 8'h82) ? MASK_CON_TIMING : (base == 8'h84) ? MASK_CHAN_SEL :
        (base == 8'h85) ? MASK_SCAN_SEL : (base == 8'h87) ? MASK_CMP_SCAN :
        (base == 8'h88) ? MASK_HIT : (base == 8'h89 || base == 8'h8A) ? MASK_IRQ : 32'h0;
    wire logic setup = psel && !penable;
    wire logic wr_acc = psel && penable && pwrite;
    ////////////////////////////////////////////////////////////////////////////////
    a_ready_no_wait: assert property (pready == (psel && penable))
        else $error("pready differs from psel and penable");
    a_unmapped_err: assert property (setup && rd_mask == 32'h0 |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_unused_zero: assert property (
        setup && rd_mask != 32'h0 |=> !pslverr && (prdata & ~$past(rd_mask)) == 32'h0)
        else $error("unimplemented bits read nonzero");
    a_match_cause: assert property (compare_match |-> $past(conv_valid, 2))
        else $error("match without a result two cycles before");
    a_scan_needs_on: assert property (scan_active |-> converter_on)
        else $error("scan active while converter off");
    a_scan_follow: assert property (
        wr_acc && paddr == OFF_SCAN_SEL |=> ##1 scan_inputs == $past(pwdata[CHANNELS-1:0], 2))
        else $error("scan inputs do not follow write");
    a_on_follow: assert property (
        wr_acc && paddr == OFF_CON_MAIN |=> ##1 converter_on == $past(pwdata[POS_ON], 2))
        else $error("converter on does not follow write");
    a_reset_quiet: assert property (disable iff (1'b0)
        !rstn |-> !irq && !compare_match && !converter_on && prdata == 32'h0)
        else $error("outputs not cleared in reset");
    c_match: cover property (compare_match);
    c_irq: cover property (irq);
    c_refused: cover property (setup ##1 pslverr);
endmodule : converter_compare_scan_control_chk

bind converter_compare_scan_control converter_compare_scan_control_chk #(
    .RESULT_W(RESULT_W), .CHANNELS(CHANNELS)) chk_inst (
    .sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_valid(conv_valid), .conv_result(conv_result), .conv_channel(conv_channel),
    .scan_end(scan_end), .converter_on(converter_on), .scan_active(scan_active),
    .scan_inputs(scan_inputs), .compare_match(compare_match), .irq(irq));

/* File: bench/converter_compare_scan_control_tb_top.sv */
// Self-checking bench for the converter compare and scan control block
`timescale 1ns/100ps
module converter_compare_scan_control_tb_top;
    import conv_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic conv_valid = 1'b0, scan_end = 1'b0;
    logic [11:0] conv_result = 12'h000;
    logic [4:0] conv_channel = 5'h00;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, converter_on, scan_active, compare_match, irq;
    wire logic [13:0] scan_inputs;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [31:0] rdata;
    logic rerr;
    logic [11:0] addrs [11] = '{OFF_BUF14, OFF_BUF15, OFF_CON_MAIN, OFF_CON_REFBUF,
        OFF_CON_TIMING, OFF_CHAN_SEL, OFF_SCAN_SEL, OFF_CMP_SCAN, OFF_HIT, OFF_IRQ_STATUS,
        OFF_IRQ_MASK};
    logic [31:0] masks [11] = '{MASK_BUF, MASK_BUF, MASK_CON_MAIN, MASK_CON_REFBUF,
        MASK_CON_TIMING, MASK_CHAN_SEL, MASK_SCAN_SEL, MASK_CMP_SCAN, MASK_HIT, MASK_IRQ,
        MASK_IRQ};
    logic [11:0] vals [3] = '{12'h063, 12'h096, 12'h0C8};

    always #10 sys_clk = ~sys_clk;

    converter_compare_scan_control #(.RESULT_W(12), .CHANNELS(14))
        converter_compare_scan_control_inst (
        .sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_valid(conv_valid), .conv_result(conv_result), .conv_channel(conv_channel),
        .scan_end(scan_end), .converter_on(converter_on), .scan_active(scan_active),
        .scan_inputs(scan_inputs), .compare_match(compare_match), .irq(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    task cmp32(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp32

    task cmp1(input string name, input logic exp, input logic got);
        cmp32(name, {31'h0, exp}, {31'h0, got});
    endtask : cmp1

    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        i = 0;
        while (pready !== 1'b1 && i < 20)
        begin
            @(posedge sys_clk);
            i++;
        end
        if (i == 20)
        begin
            n_mismatch++;
            close_out;
        end
        else
        begin
            rdata = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task rd(input logic [11:0] a, input logic [31:0] exp, input string name);
        apb(a, 1'b0, 32'h0);
        cmp32(name, exp, rdata);
    endtask : rd

    task conv(input logic [11:0] r, input logic [4:0] ch);
        @(posedge sys_clk);
        conv_valid <= 1'b1;
        conv_result <= r;
        conv_channel <= ch;
        @(posedge sys_clk);
        conv_valid <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask : conv

    task pulse_scan_end;
        @(posedge sys_clk);
        scan_end <= 1'b1;
        @(posedge sys_clk);
        scan_end <= 1'b0;
        @(posedge sys_clk);
    endtask : pulse_scan_end

    // Expected match for buffer pair 100 and 200, window inclusive
    function automatic logic want_match(int m, logic [11:0] r);
        case (m)
            0: return r < 12'h064;
            1: return r > 12'h064;
            2: return r >= 12'h064 && r <= 12'h0C8;
            default: return !(r >= 12'h064 && r <= 12'h0C8);
        endcase
    endfunction : want_match
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset_values;
        for (int i = 0; i < 11; i++)
            rd(addrs[i], 32'h0, "reset value");
    endtask : t_reset_values

    task t_masks;
        for (int i = 0; i < 11; i++)
        begin
            if (i != 9)
            begin
                apb(addrs[i], 1'b1, 32'hFFFF_FFFF);
                rd(addrs[i], (i == 8) ? 32'h0 : masks[i], "implemented bits");
                apb(addrs[i], 1'b1, 32'h0);
            end
        end
    endtask : t_masks

    task t_alias;
        apb(OFF_SCAN_SEL, 1'b1, 32'h0000_000F);
        apb(OFF_SCAN_SEL + 12'h4, 1'b1, 32'h0000_0003);
        rd(OFF_SCAN_SEL, 32'h0000_000C, "clear alias");
        apb(OFF_SCAN_SEL + 12'h8, 1'b1, 32'h0000_0030);
        rd(OFF_SCAN_SEL, 32'h0000_003C, "set alias");
        apb(OFF_SCAN_SEL + 12'hC, 1'b1, 32'h0000_3FFF);
        rd(OFF_SCAN_SEL, 32'h0000_3FC3, "invert alias");
        @(posedge sys_clk);
        #1;
        cmp32("scan_inputs", 32'h0000_3FC3, {18'h0, scan_inputs});
    endtask : t_alias

    task t_compare;
        logic e;
        logic [31:0] hit_exp;
        hit_exp = 32'h0;
        apb(OFF_BUF14, 1'b1, 32'h0000_0064);
        apb(OFF_BUF15, 1'b1, 32'h0000_00C8);
        apb(OFF_CON_MAIN, 1'b1, 32'h0000_8000);
        for (int m = 0; m < 4; m++)
        begin
            apb(OFF_CMP_SCAN, 1'b1, 32'h0000_0004 | 32'(m));
            for (int k = 0; k < 3; k++)
            begin
                e = want_match(m, vals[k]);
                conv(vals[k], 5'(m * 3 + k));
                cmp1("compare_match", e, compare_match);
                hit_exp[m * 3 + k] = e;
            end
        end
        rd(OFF_HIT, hit_exp, "channel hits");
        apb(OFF_HIT + 12'h4, 1'b1, 32'h0000_3FFF);
        rd(OFF_HIT, 32'h0, "hits cleared");
    endtask : t_compare

    task t_irq;
        apb(OFF_IRQ_STATUS, 1'b0, 32'h0);
        apb(OFF_IRQ_MASK, 1'b1, 32'h0);
        conv(12'h032, 5'h00);
        @(posedge sys_clk);
        #1;
        cmp1("irq masked", 1'b0, irq);
        apb(OFF_IRQ_MASK, 1'b1, 32'h0000_0002);
        repeat (2) @(posedge sys_clk);
        #1;
        cmp1("irq raised", 1'b1, irq);
        rd(OFF_IRQ_STATUS, 32'h0000_0003, "status count and match");
        repeat (2) @(posedge sys_clk);
        #1;
        cmp1("irq cleared", 1'b0, irq);
        apb(OFF_CON_REFBUF, 1'b1, 32'h0000_0008);
        conv(12'h096, 5'h01);
        conv(12'h096, 5'h01);
        rd(OFF_IRQ_STATUS, 32'h0, "count before third");
        conv(12'h096, 5'h01);
        rd(OFF_IRQ_STATUS, 32'h0000_0001, "count after third");
        apb(OFF_CMP_SCAN, 1'b1, 32'h0000_8004);
        conv(12'h032, 5'h02);
        pulse_scan_end;
        rd(OFF_IRQ_STATUS, 32'h0, "auto scan overrides");
        apb(OFF_CMP_SCAN, 1'b1, 32'h0000_8204);
        pulse_scan_end;
        cmp1("scan_active on", 1'b1, scan_active);
        rd(OFF_IRQ_STATUS, 32'h0000_0004, "scan end event");
        apb(OFF_CMP_SCAN, 1'b1, 32'h0000_0304);
        pulse_scan_end;
        cmp1("scan_active off", 1'b0, scan_active);
        rd(OFF_IRQ_STATUS, 32'h0, "selection idle");
    endtask : t_irq

    task t_unmapped;
        apb(12'h900, 1'b0, 32'h0);
        cmp32("unmapped data", 32'h0, rdata);
        cmp1("unmapped error", 1'b1, rerr);
    endtask : t_unmapped

    initial
    begin
        rstn <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset_values;
        t_masks;
        t_alias;
        t_compare;
        t_irq;
        t_unmapped;
        close_out;
    end
endmodule : converter_compare_scan_control_tb_top
